//--- include/rsp_pkg.sv
`default_nettype none

package rsp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_FREQ_MHZ    = 100;
   localparam int unsigned CAPT_WINDOW_US  = 10;
   // Longest time, so the cycle count rounds down
   localparam int unsigned CAPT_WINDOW_CYC = CAPT_WINDOW_US * CLK_FREQ_MHZ;
   // Converter fields are taken a quarter of the way into the window
   localparam int unsigned CAPT_SETTLE_CYC = CAPT_WINDOW_CYC / 4;
   localparam int unsigned SETTLE_CNT_W    = 10;

   ////////////////////////////////////////////////////////////////////////////
   // Buffer and sample layout
   localparam int unsigned BUF_DEPTH_DFLT = 2048;
   localparam int unsigned SAMPLE_BYTES   = 8;
   localparam int unsigned IRQ_LINES      = 6;

   ////////////////////////////////////////////////////////////////////////////
   // Host port map
   localparam logic [1:0] ADDR_DATA     = 2'h0;
   localparam logic [1:0] ADDR_STATUS   = 2'h1;
   localparam logic [1:0] CMD_CLR_OVF   = 2'h0;
   localparam logic [1:0] CMD_BOARD_RST = 2'h3;
   localparam int unsigned STAT_AVAIL_BIT = 0;
   localparam int unsigned STAT_HALF_BIT  = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [7:0] ENC_RST   = 8'h00;
   localparam logic [5:0] IRQ_RST   = 6'h00;

   // Byte 0 sits in the low bits, byte 7 in the high bits
   typedef struct packed {
      logic [7:0]  enc2;
      logic [7:0]  enc1;
      logic [15:0] range_hi;
      logic [2:0]  range_lo;
      logic        zero;
      logic        ovf;
      logic        gp3;
      logic        gp2;
      logic        gp1;
      logic [7:0]  temperature;
      logic [7:0]  ambient;
      logic [7:0]  amplitude;
   } rsp_sample_t;

   typedef struct packed {
      logic        start;
      logic [7:0]  amplitude;
      logic [7:0]  ambient;
      logic [7:0]  temperature;
      logic [18:0] range;
      logic [2:0]  gp;
      logic [1:0]  enc_a;
      logic [1:0]  enc_b;
      logic [5:0]  jumper;
   } rsp_pins_t;

   typedef enum logic [1:0] {
      RSP_IDLE,
      RSP_SETTLE,
      RSP_STORE
   } rsp_state_t;

endpackage : rsp_pkg

`default_nettype wire

//--- logic/rsp_sample_packer.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Amplitude byte taken early in each interval
// - Ambient light byte taken early in interval
// - Temperature byte taken early in interval
// - Range low three bits byte3, rest bytes4-5
// - Lost samples set overflow in next stored
// - Overflow stays set until clear or reset
// - Overflow flag is stored with each sample
// - Clear while full sets overflow again
// - Inputs 1 and 2 latched high per interval
// - Input 3 inverted, unlatched, current level
// - Two 8-bit encoder counts, wrapping past 255
// - Interrupt while buffer at least half full
// - Interrupt on one jumper-selected line or none
// - Interrupt drops below half or board reset
// - One sample per interval, up to 50000/s
// - Byte order and byte 3 bit layout
// - Data write command: 00 clear, 11 reset
// - Board reset clears flag, buffer, encoders
// - Overflow drops whole eight-byte samples only
module rsp_sample_packer
   import rsp_pkg::*;
#(
   parameter int unsigned BUF_DEPTH = BUF_DEPTH_DFLT
) (
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   input  wire logic [1:0]  bus_addr_i,
   input  wire logic [7:0]  bus_wdata_i,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_rd_i,
   output var  logic [7:0]  bus_rdata_o,
   input  wire logic        sample_start_i,
   input  wire logic [7:0]  amplitude_i,
   input  wire logic [7:0]  ambient_i,
   input  wire logic [7:0]  temperature_i,
   input  wire logic [18:0] range_i,
   input  wire logic [2:0]  gp_in_i,
   input  wire logic [1:0]  enc_a_i,
   input  wire logic [1:0]  enc_b_i,
   input  wire logic [5:0]  interrupt_select_jumper_i,
   output var  logic [5:0]  irq_o
);

   localparam int unsigned AW    = $clog2(BUF_DEPTH);
   localparam int unsigned PTR_W = AW + 1;
   localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(BUF_DEPTH);
   localparam logic [PTR_W-1:0] HALF_P  = PTR_W'(BUF_DEPTH / 2);
   localparam logic [PTR_W-1:0] SMP_P   = PTR_W'(SAMPLE_BYTES);
   localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(CAPT_SETTLE_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   rsp_pins_t pins_raw;
   rsp_pins_t pins_s1_q;
   rsp_pins_t pins_q;

   assign pins_raw = '{start:       sample_start_i,
                       amplitude:   amplitude_i,
                       ambient:     ambient_i,
                       temperature: temperature_i,
                       range:       range_i,
                       gp:          gp_in_i,
                       enc_a:       enc_a_i,
                       enc_b:       enc_b_i,
                       jumper:      interrupt_select_jumper_i};

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pins_s1_q <= '0;
         pins_q    <= '0;
      end else begin
         pins_s1_q <= pins_raw;
         pins_q    <= pins_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host port decode

   logic             wr_data;
   logic             cmd_clr;
   logic             cmd_rst;
   logic             rd_data;
   logic             rd_status;
   logic             rd_pop;
   logic [PTR_W-1:0] wptr_q;
   logic [PTR_W-1:0] rptr_q;
   logic [PTR_W-1:0] count;
   logic             avail;
   logic             half;
   logic             room;

   assign wr_data = bus_wr_i && (bus_addr_i == ADDR_DATA);
   assign cmd_clr = wr_data && (bus_wdata_i[1:0] == CMD_CLR_OVF);
   assign cmd_rst = wr_data && (bus_wdata_i[1:0] == CMD_BOARD_RST);
   assign rd_data = bus_rd_i && (bus_addr_i == ADDR_DATA);
   assign rd_status = bus_rd_i && (bus_addr_i == ADDR_STATUS);
   // A read of an empty buffer leaves the pointer where it is
   assign rd_pop    = rd_data && avail;

   // Committed pointers only; bytes of a sample in progress stay hidden
   assign count = wptr_q - rptr_q;
   assign avail = (count != '0);
   assign half  = (count >= HALF_P);
   assign room  = ((DEPTH_P - count) >= SMP_P);

   ////////////////////////////////////////////////////////////////////////////
   // Encoder counters

   logic [1:0] enc_a_prev_q;
   logic [1:0] enc_b_prev_q;
   logic [7:0] enc_cnt_q [2];

   for (genvar e = 0; e < 2; e++) begin : g_enc
      logic step;
      logic up;
      assign step = (pins_q.enc_a[e] ^ enc_a_prev_q[e]) ^ (pins_q.enc_b[e] ^ enc_b_prev_q[e]);
      assign up   = enc_a_prev_q[e] ^ pins_q.enc_b[e];

      always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            enc_a_prev_q[e] <= 1'b0;
            enc_b_prev_q[e] <= 1'b0;
            enc_cnt_q[e]    <= ENC_RST;
         end else begin
            enc_a_prev_q[e] <= pins_q.enc_a[e];
            enc_b_prev_q[e] <= pins_q.enc_b[e];
            if (cmd_rst) begin
               enc_cnt_q[e] <= ENC_RST;
            end else if (step) begin
               // Eight-bit arithmetic wraps 255 to 0 and 0 to 255
               enc_cnt_q[e] <= up ? enc_cnt_q[e] + 8'h01 : enc_cnt_q[e] - 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture sequencer

   rsp_state_t              state_q;
   rsp_state_t              state_d;
   logic                    start_prev_q;
   logic                    start_edge;
   logic [SETTLE_CNT_W-1:0] settle_q;
   logic [2:0]              byte_idx_q;
   logic [1:0]              gp_hold_q;
   logic [1:0]              gp_seen;
   logic                    ovf_q;
   logic                    ovf_d;
   logic                    snap;
   logic                    lose;
   logic                    commit;
   logic                    settling;
   logic                    store_en;
   rsp_sample_t             sample_q;
   rsp_sample_t             sample_d;

   assign start_edge = pins_q.start && !start_prev_q;
   assign settling   = (state_q == RSP_SETTLE);
   assign store_en   = (state_q == RSP_STORE);
   assign snap       = settling && (settle_q == SETTLE_LAST);
   assign lose       = snap && !room;
   assign commit     = store_en && (byte_idx_q == 3'h7);
   assign gp_seen    = gp_hold_q | pins_q.gp[1:0];

   // A new interval start is ignored while a sample is still in flight
   always_comb begin
      state_d = state_q;
      case (state_q)
         RSP_IDLE: begin
            if (start_edge) begin
               state_d = RSP_SETTLE;
            end
         end
         RSP_SETTLE: begin
            if (snap) begin
               state_d = room ? RSP_STORE : RSP_IDLE;
            end
         end
         RSP_STORE: begin
            if (commit) begin
               state_d = RSP_IDLE;
            end
         end
         default: begin
            state_d = RSP_IDLE;
         end
      endcase
      if (cmd_rst) begin
         state_d = RSP_IDLE;
      end
   end

   always_comb begin
      sample_d             = sample_q;
      if (snap) begin
         sample_d.amplitude   = pins_q.amplitude;
         sample_d.ambient     = pins_q.ambient;
         sample_d.temperature = pins_q.temperature;
         sample_d.range_lo    = pins_q.range[2:0];
         sample_d.range_hi    = pins_q.range[18:3];
         sample_d.zero        = 1'b0;
         sample_d.ovf         = ovf_q;
         sample_d.gp3         = ~pins_q.gp[2];
         sample_d.gp2         = gp_seen[1];
         sample_d.gp1         = gp_seen[0];
         sample_d.enc1        = enc_cnt_q[0];
         sample_d.enc2        = enc_cnt_q[1];
      end
   end

   // Loss sets the flag, and a loss in the clear cycle still wins
   always_comb begin
      ovf_d = ovf_q;
      if (cmd_clr) begin
         ovf_d = !room;
      end
      if (lose) begin
         ovf_d = 1'b1;
      end
      if (cmd_rst) begin
         ovf_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q      <= RSP_IDLE;
         start_prev_q <= 1'b0;
         ovf_q        <= 1'b0;
         sample_q     <= '0;
      end else begin
         state_q      <= state_d;
         start_prev_q <= pins_q.start;
         ovf_q        <= ovf_d;
         sample_q     <= sample_d;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         settle_q   <= '0;
         byte_idx_q <= 3'h0;
      end else begin
         settle_q   <= settling ? settle_q + 1'b1 : '0;
         byte_idx_q <= store_en ? byte_idx_q + 3'h1 : 3'h0;
      end
   end

   // High levels on inputs 1 and 2 are held until the next snapshot
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gp_hold_q <= 2'h0;
      end else if (cmd_rst) begin
         gp_hold_q <= 2'h0;
      end else if (snap) begin
         gp_hold_q <= pins_q.gp[1:0];
      end else begin
         gp_hold_q <= gp_seen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample buffer

   logic [7:0]    mem [BUF_DEPTH];
   logic [63:0]   sample_bits;
   logic [7:0]    store_byte;
   logic [AW-1:0] store_addr;
   logic [AW-1:0] read_addr;

   assign sample_bits = sample_q;
   assign store_byte  = sample_bits[{byte_idx_q, 3'b000} +: 8];
   assign store_addr  = wptr_q[AW-1:0] + AW'(byte_idx_q);
   assign read_addr   = rptr_q[AW-1:0];

   always_ff @(posedge clk_sys_i) begin
      if (store_en) begin
         mem[store_addr] <= store_byte;
      end
   end

   // The write pointer moves by a whole sample once all eight bytes are in
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wptr_q <= '0;
         rptr_q <= '0;
      end else if (cmd_rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
      end else begin
         if (commit) begin
            wptr_q <= wptr_q + SMP_P;
         end
         if (rd_pop) begin
            rptr_q <= rptr_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   logic [7:0] status_byte;
   logic [7:0] rdata_d;

   assign status_byte = 8'(({7'h00, half} << STAT_HALF_BIT) | ({7'h00, avail} << STAT_AVAIL_BIT));
   assign rdata_d     = rd_data   ? mem[read_addr] :
                        rd_status ? status_byte    : RDATA_RST;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_rdata_o <= RDATA_RST;
      end else begin
         bus_rdata_o <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt

   logic [5:0] irq_sel;
   logic [5:0] irq_d;

   // Lowest closed jumper pair wins so at most one line is ever driven
   assign irq_sel = pins_q.jumper & (~pins_q.jumper + 6'h01);
   assign irq_d   = half ? irq_sel : IRQ_RST;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o <= IRQ_RST;
      end else begin
         irq_o <= irq_d;
      end
   end

endmodule : rsp_sample_packer

`default_nettype wire

//--- verification/rsp_sample_packer_properties.sv
`timescale 1ns/1ps
`default_nettype none

module rsp_sample_packer_properties
   import rsp_pkg::*;
#(
   parameter int unsigned BUF_DEPTH = BUF_DEPTH_DFLT
) (
   input  wire logic       clk_sys_i,
   input  wire logic       arst_n_i,
   input  wire logic [1:0] bus_addr_i,
   input  wire logic [7:0] bus_wdata_i,
   input  wire logic       bus_wr_i,
   input  wire logic       bus_rd_i,
   input  wire logic [7:0] bus_rdata_o,
   input  wire logic [5:0] interrupt_select_jumper_i,
   input  wire logic [5:0] irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_board_rst;
      bus_wr_i && bus_addr_i == ADDR_DATA && bus_wdata_i[1:0] == CMD_BOARD_RST;
   endsequence
   sequence s_stat_rd;
      bus_rd_i && bus_addr_i == ADDR_STATUS;
   endsequence

   AST_RDATA_IDLE: assert property (!bus_rd_i |=> bus_rdata_o == 8'h00)
      else $error("read data not zero outside a read answer");
   AST_IRQ_ONEHOT: assert property ($onehot0(irq_o))
      else $error("more than one interrupt line driven");
   AST_IRQ_LINE: assert property (irq_o != 6'h00 && $stable(interrupt_select_jumper_i)
      && $past(interrupt_select_jumper_i, 1) == $past(interrupt_select_jumper_i, 3)
      |-> irq_o == (interrupt_select_jumper_i & (~interrupt_select_jumper_i + 6'h01)))
      else $error("interrupt on a line other than the selected one");
   AST_RST_DROPS_IRQ: assert property (s_board_rst |-> ##2 irq_o == 6'h00)
      else $error("interrupt kept after board reset");
   AST_RST_EMPTIES: assert property (s_board_rst ##2 s_stat_rd |=> bus_rdata_o == 8'h00)
      else $error("status not empty after board reset");
   AST_IRQ_FALL: assert property ($fell(|irq_o)
      |-> $past(bus_rd_i, 2) || $past(bus_wr_i, 2))
      else $error("interrupt dropped without read or reset");
   AST_UNMAPPED: assert property (bus_rd_i && bus_addr_i[1] |=> bus_rdata_o == 8'h00)
      else $error("unmapped offset read not zero");
   AST_HALF_IRQ: assert property (s_stat_rd and (irq_o != 6'h00 && !$past(bus_rd_i)
      && !$past(bus_wr_i)) |=> bus_rdata_o[1:0] == 2'h3)
      else $error("interrupt high while status shows under half");
endmodule : rsp_sample_packer_properties

bind rsp_sample_packer rsp_sample_packer_properties #(.BUF_DEPTH(BUF_DEPTH)) u_props (
   .clk_sys_i                 (clk_sys_i),
   .arst_n_i                  (arst_n_i),
   .bus_addr_i                (bus_addr_i),
   .bus_wdata_i               (bus_wdata_i),
   .bus_wr_i                  (bus_wr_i),
   .bus_rd_i                  (bus_rd_i),
   .bus_rdata_o               (bus_rdata_o),
   .interrupt_select_jumper_i (interrupt_select_jumper_i),
   .irq_o                     (irq_o)
);

`default_nettype wire

//--- verification/rsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module rsp_host_model
   import rsp_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] bus_rdata_i,
   output var  logic [1:0] bus_addr_o,
   output var  logic [7:0] bus_wdata_o,
   output var  logic       bus_wr_o,
   output var  logic       bus_rd_o
);
   initial begin
      bus_addr_o = 2'h0;
      bus_wdata_o = 8'h00;
      bus_wr_o = 1'b0;
      bus_rd_o = 1'b0;
   end

   // Command byte: low two bits select clear or board reset
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      bus_addr_o <= a;
      bus_wdata_o <= d;
      bus_wr_o <= 1'b1;
      @(posedge clk_sys_i);
      bus_wr_o <= 1'b0;
      @(posedge clk_sys_i);
   endtask : wr

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      bus_addr_o <= a;
      bus_rd_o <= 1'b1;
      @(posedge clk_sys_i);
      bus_rd_o <= 1'b0;
      @(posedge clk_sys_i);
      d = bus_rdata_i;
   endtask : rd

   // Whole sample, byte 0 first; flagged samples are not trusted
   task automatic rd_sample(output rsp_sample_t s, output logic discard);
      logic [7:0] b;
      for (int i = 0; i < SAMPLE_BYTES; i++) begin
         rd(ADDR_DATA, b);
         s[8*i +: 8] = b;
      end
      discard = s.ovf;
   endtask : rd_sample
endmodule : rsp_host_model

`default_nettype wire

//--- verification/rsp_sample_packer_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end

module rsp_sample_packer_tb;
   import rsp_pkg::*;

   logic        clk_sys_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic [1:0]  bus_addr;
   logic [7:0]  bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [7:0]  bus_rdata;
   logic        sample_start_i = 1'b0;
   logic [7:0]  amplitude_i = 8'h00;
   logic [7:0]  ambient_i = 8'h00;
   logic [7:0]  temperature_i = 8'h00;
   logic [18:0] range_i = 19'h00000;
   logic [2:0]  gp_in_i = 3'h4;
   logic [1:0]  enc_a_i = 2'h0;
   logic [1:0]  enc_b_i = 2'h0;
   logic [5:0]  interrupt_select_jumper_i = 6'h00;
   logic [5:0]  irq_o;
   logic [1:0]  ph1 = 2'h0;
   logic [1:0]  ph2 = 2'h0;
   logic        g3 = 1'b1;
   logic [7:0]  d;
   int          err_count = 0;
   int          comparisons = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   rsp_sample_packer #(.BUF_DEPTH(16)) u_dut (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus_addr_i(bus_addr),
      .bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata),
      .sample_start_i(sample_start_i), .amplitude_i(amplitude_i), .ambient_i(ambient_i),
      .temperature_i(temperature_i), .range_i(range_i), .gp_in_i(gp_in_i),
      .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
      .interrupt_select_jumper_i(interrupt_select_jumper_i), .irq_o(irq_o));

   rsp_host_model u_host (
      .clk_sys_i(clk_sys_i), .bus_rdata_i(bus_rdata), .bus_addr_o(bus_addr),
      .bus_wdata_o(bus_wdata), .bus_wr_o(bus_wr), .bus_rd_o(bus_rd));

   ////////////////////////////////////////////////////////////////////////////
   function automatic rsp_sample_t mk(input logic [7:0] a, input logic ovf, input logic p,
                                      input logic [7:0] e1, input logic [7:0] e2);
      mk = '{enc2: e2, enc1: e1, range_hi: {a, 8'h5C}, range_lo: 3'h3, zero: 1'b0, ovf: ovf,
             gp3: ~g3, gp2: 1'b0, gp1: p, temperature: a ^ 8'h5A, ambient: ~a, amplitude: a};
   endfunction : mk

   // Gray order 00 01 11 10 counts up
   task automatic enc_step(input logic [1:0] m);
      ph1 = ph1 + {1'b0, m[0]};
      ph2 = ph2 + {1'b0, m[1]};
      enc_a_i <= {ph2[1], ph1[1]};
      enc_b_i <= {ph2[1] ^ ph2[0], ph1[1] ^ ph1[0]};
      repeat (4) @(posedge clk_sys_i);
   endtask : enc_step

   task automatic sample(input logic [7:0] a, input logic p);
      amplitude_i <= a;
      ambient_i <= ~a;
      temperature_i <= a ^ 8'h5A;
      range_i <= {a, 11'h2E3};
      gp_in_i <= {g3, 1'b0, p};
      sample_start_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      sample_start_i <= 1'b0;
      gp_in_i <= {g3, 2'b00};
      repeat (CAPT_WINDOW_CYC - 4) @(posedge clk_sys_i);
      // Converter fields after the capture window must never reach the sample
      amplitude_i <= 8'hA5;
      ambient_i <= 8'hA5;
      temperature_i <= 8'hA5;
      range_i <= 19'h7FFFF;
      // Start edges stay 20 us apart, the fastest sample rate allowed
      repeat (CAPT_WINDOW_CYC) @(posedge clk_sys_i);
   endtask : sample

   task automatic chk_sample(input rsp_sample_t e);
      rsp_sample_t got;
      logic        dis;
      u_host.rd_sample(got, dis);
      for (int i = 0; i < SAMPLE_BYTES; i++) begin
         `CHK(got[8*i +: 8], e[8*i +: 8])
      end
      `CHK(dis, e.ovf)
   endtask : chk_sample

   task automatic results;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (60000) @(posedge clk_sys_i);
      err_count++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      u_host.rd(ADDR_STATUS, d);
      `CHK(d, 8'h00)
      u_host.rd(2'h2, d);
      `CHK(d, 8'h00)
      for (int i = 0; i < 257; i++) enc_step({i < 3, 1'b1});
      for (int k = 0; k < 7; k++) begin
         interrupt_select_jumper_i <= (k < 6) ? 6'h01 << k : 6'h00;
         repeat (4) @(posedge clk_sys_i);
         sample(8'h10 + 8'(k), k == 0);
         u_host.rd(ADDR_STATUS, d);
         `CHK(d, 8'h03)
         `CHK(irq_o, interrupt_select_jumper_i)
         chk_sample(mk(8'h10 + 8'(k), 1'b0, k == 0, 8'h01, 8'h03));
         repeat (2) @(posedge clk_sys_i);
         `CHK(irq_o, 6'h00)
      end
      interrupt_select_jumper_i <= 6'h04;
      sample(8'h21, 1'b0);
      sample(8'h22, 1'b0);
      sample(8'h23, 1'b0);
      u_host.wr(ADDR_DATA, {6'h00, CMD_CLR_OVF});
      `CHK(irq_o, 6'h04)
      chk_sample(mk(8'h21, 1'b0, 1'b0, 8'h01, 8'h03));
      chk_sample(mk(8'h22, 1'b0, 1'b0, 8'h01, 8'h03));
      sample(8'h24, 1'b0);
      chk_sample(mk(8'h24, 1'b1, 1'b0, 8'h01, 8'h03));
      u_host.wr(ADDR_DATA, 8'h01);
      u_host.wr(ADDR_DATA, 8'h02);
      sample(8'h25, 1'b0);
      chk_sample(mk(8'h25, 1'b1, 1'b0, 8'h01, 8'h03));
      u_host.wr(ADDR_DATA, 8'hFC);
      sample(8'h26, 1'b0);
      chk_sample(mk(8'h26, 1'b0, 1'b0, 8'h01, 8'h03));
      sample(8'h31, 1'b0);
      sample(8'h32, 1'b0);
      sample(8'h33, 1'b0);
      for (int i = 0; i < 3; i++) u_host.rd(ADDR_DATA, d);
      u_host.wr(ADDR_DATA, {6'h00, CMD_BOARD_RST});
      u_host.rd(ADDR_STATUS, d);
      `CHK(d, 8'h00)
      `CHK(irq_o, 6'h00)
      g3 = 1'b0;
      sample(8'h34, 1'b0);
      chk_sample(mk(8'h34, 1'b0, 1'b0, 8'h00, 8'h00));
      results();
   end
endmodule : rsp_sample_packer_tb

`default_nettype wire
